/* File: verilog/key_slot_pkg.sv */
`default_nettype none
package key_slot_pkg;
  localparam int SLOTS       = 16;
  localparam int AES_ENTRIES = 4;
  localparam int HALF        = 16;

  localparam logic [3:0] SLOT_PRIMARY     = 4'h0;
  localparam logic [3:0] SLOT_ATTEST      = 4'h1;
  localparam logic [3:0] SLOT_SEC_LO      = 4'h2;
  localparam logic [3:0] SLOT_SEC_HI      = 4'h4;
  localparam logic [3:0] SLOT_SECRET      = 4'h5;
  localparam logic [3:0] SLOT_IOKEY       = 4'h6;
  localparam logic [3:0] SLOT_BOOT_DIG    = 4'h7;
  localparam logic [3:0] SLOT_AES         = 4'h9;
  localparam logic [3:0] SLOT_DEV_CERT    = 4'hA;
  localparam logic [3:0] SLOT_SIGNER_PUB  = 4'hB;
  localparam logic [3:0] SLOT_SIGNER_CERT = 4'hC;
  localparam logic [3:0] SLOT_PARENT      = 4'hD;
  localparam logic [3:0] SLOT_VALIDATED   = 4'hE;
  localparam logic [3:0] SLOT_BOOT_PUB    = 4'hF;

  localparam logic [15:0] LOCK_RESET    = 16'hFFFF;
  localparam logic [15:0] LOCKABLE_MASK = 16'hBD7C;
  localparam logic [15:0] NO_READ_MASK  = 16'h02FF;
  localparam logic [15:0] NO_WRITE_MASK = 16'h009F;

  localparam logic [7:0] MODE_PUBKEY = 8'h00;
  localparam logic [7:0] MODE_REGEN  = 8'h04;
  localparam int MODE_ENC_BIT  = 7;
  localparam int MODE_SAVE_BIT = 6;
  localparam int MODE_IDX_LSB  = 4;
  localparam int MODE_SUB_LSB  = 0;
  localparam logic [1:0] SUB_VALIDATE    = 2'h0;
  localparam logic [1:0] SUB_INVALIDATE  = 2'h1;
  localparam logic [1:0] SUB_USE         = 2'h2;
  localparam logic [1:0] SUB_BOOT_UPDATE = 2'h1;

  localparam logic [31:0] KEY_SEED  = 32'hA5C3_0F17;
  localparam logic [31:0] MIX_CONST = 32'h9E37_79B9;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_DIN  = 8'h08;
  localparam logic [7:0] REG_DOUT = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int CTRL_GO        = 0;
  localparam int CTRL_PAIR      = 1;
  localparam int CTRL_CHECK     = 2;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_MODE_LSB   = 8;
  localparam int CMD_SLOT_LSB   = 16;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_ST_LSB    = 1;
  localparam int STAT_PAIRED    = 3;
  localparam int STAT_PAIR_OK   = 4;
  localparam int STAT_LOCKS_LSB = 16;

  typedef enum logic [3:0] {
    CMD_READ, CMD_WRITE, CMD_GENKEY, CMD_LOCK, CMD_SIGN, CMD_ECDH,
    CMD_VERIFY, CMD_DIGEST, CMD_MAC, CMD_BOOT, CMD_RANDOM, CMD_KDF
  } cmd_t;

  typedef enum logic [1:0] {ST_OK, ST_DENIED, ST_BAD_SIG} status_t;

  // Stand-in for the curve and hash arithmetic
  function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] b);
    return {a[HALF-1:0], a[31:HALF]} ^ b ^ MIX_CONST;
  endfunction

  function automatic logic is_private(input logic [3:0] s);
    return s <= SLOT_SEC_HI;
  endfunction

  function automatic logic is_secondary(input logic [3:0] s);
    return s >= SLOT_SEC_LO && s <= SLOT_SEC_HI;
  endfunction

  function automatic logic is_sym(input logic [3:0] s);
    return s == SLOT_SECRET || s == SLOT_IOKEY || s == SLOT_AES;
  endfunction

  function automatic logic is_prot(input cmd_t op);
    return op == CMD_ECDH || op == CMD_VERIFY || op == CMD_BOOT || op == CMD_KDF;
  endfunction
endpackage
`default_nettype wire

/* File: verilog/key_slot_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface key_slot_if
  import key_slot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n
);
  logic        req;
  cmd_t        op;
  logic [7:0]  mode;
  logic [3:0]  slot;
  logic [31:0] wdata;
  logic        enc_write;
  logic        rsp_valid;
  status_t     status;
  logic [31:0] rdata;

  modport dev (input clk_sys, input rst_n, input req, input op, input mode, input slot,
               input wdata, input enc_write, output rsp_valid, output status, output rdata);
  modport host (input clk_sys, input rst_n, output req, output op, output mode,
                output slot, output wdata, output enc_write, input rsp_valid,
                input status, input rdata);
endinterface
`default_nettype wire

/* File: verilog/slot_lock_bits.sv */
`timescale 1ns/1ps
`default_nettype none
module slot_lock_bits
  import key_slot_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             lock_en,
  input  wire logic [3:0]       lock_slot,
  output logic      [SLOTS-1:0] state_bits_reg
);
  logic [SLOTS-1:0] state_bits_next;

  // A cleared bit never returns to one
  always_comb begin
    state_bits_next = state_bits_reg;
    if (lock_en) begin
      state_bits_next[lock_slot] = 1'b0; // [R22] [R23]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_bits_reg <= LOCK_RESET; // [R22]
    end else begin
      state_bits_reg <= state_bits_next;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/key_slot_device.sv */
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Private key slots never readable
// [R2] Primary key fixed; sign and ECDH only
// [R3] Key generation mode 0x00 gives public key
// [R4] Mode 0x04 regenerates unlocked secondary key
// [R5] Lockable slot locks; locked key not regenerated
// [R6] Slot 1 signs internal messages only
// [R7] Host writes and locks parent key
// [R8] Validated key usable only while validated
// [R9] Host leaves validated slot unlocked
// [R10] Certificates in slots 10, 11, 12
// [R11] Certificate slots lockable or fixed permanent
// [R12] Boot key in slot 15, locked first
// [R13] Slot 7 holds firmware digest, refreshable
// [R14] Primary key optionally gated by boot
// [R15] Secret slot feeds symmetric commands
// [R16] Secret slot written only encrypted
// [R17] Derived keys optionally saved, several entries
// [R18] Protected commands encrypt under I/O key
// [R19] Host pairs: random, store, write, lock
// [R20] Host pairs before encrypted ECDH output
// [R21] Host checks pairing by MAC challenge
// [R22] Lock bits start one, cleared on lock
// [R23] Slot locks once, never unlocks
// [R24] Violations rejected, contents unchanged
module key_slot_device
  import key_slot_pkg::*;
#(
  parameter logic CERT_PERMANENT     = 1'b0,
  parameter logic BOOT_GATES_PRIMARY = 1'b0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  key_slot_if.dev               link,
  output logic      [SLOTS-1:0] slot_lock_state_bits,
  output logic                  boot_ok,
  output logic                  key_validated
);
  logic [31:0] slot_mem  [SLOTS];
  logic [31:0] slot_next [SLOTS];
  logic [31:0] aes_mem   [AES_ENTRIES];
  logic [31:0] aes_next  [AES_ENTRIES];
  logic [31:0] lfsr_reg;
  logic [31:0] lfsr_next;
  logic [31:0] int_data_reg;
  logic [31:0] int_data_next;
  logic        int_valid_reg;
  logic        int_valid_next;
  logic        valid_reg;
  logic        valid_next;
  logic        boot_ok_reg;
  logic        boot_ok_next;
  logic        rsp_valid_reg;
  logic        rsp_valid_next;
  status_t     status_reg;
  status_t     status_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        lock_en, ok, bad_sig, save;
  logic [31:0] res;
  logic [3:0]  s;
  logic [7:0]  m;
  logic [1:0]  sub;
  logic [1:0]  aes_idx;
  logic        enc;
  logic        prot;
  logic        locked;
  logic        io_ready;
  logic        io_bad;
  logic        prim_ok;
  logic        use_ok;
  logic        cert;
  logic [31:0] iokey;
  logic [31:0] din;
  logic [31:0] key;

  slot_lock_bits slot_lock_bits_i (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .lock_en        (lock_en),
    .lock_slot      (s),
    .state_bits_reg (slot_lock_state_bits)
  );

  assign s        = link.slot;
  assign m        = link.mode;
  assign sub      = m[MODE_SUB_LSB +: 2];
  assign aes_idx  = m[MODE_IDX_LSB +: 2];
  assign enc      = m[MODE_ENC_BIT];
  assign prot     = is_prot(link.op);
  assign locked   = !slot_lock_state_bits[s];
  assign iokey    = slot_mem[SLOT_IOKEY];
  assign io_ready = !slot_lock_state_bits[SLOT_IOKEY];
  assign io_bad   = prot && enc && !io_ready; // [R18]
  assign din      = (prot && enc) ? link.wdata ^ iokey : link.wdata; // [R18]
  assign prim_ok  = !BOOT_GATES_PRIMARY || boot_ok_reg; // [R14]
  assign use_ok   = (s == SLOT_PRIMARY) ? prim_ok : is_secondary(s); // [R2]
  assign cert     = s == SLOT_DEV_CERT || s == SLOT_SIGNER_PUB || s == SLOT_SIGNER_CERT; // [R10]
  assign key      = (s == SLOT_AES) ? aes_mem[aes_idx] : slot_mem[s]; // [R17]

  assign link.rsp_valid = rsp_valid_reg;
  assign link.status    = status_reg;
  assign link.rdata     = rdata_reg;
  assign boot_ok        = boot_ok_reg;
  assign key_validated  = valid_reg;

  always_comb begin
    slot_next      = slot_mem;
    aes_next       = aes_mem;
    lfsr_next      = {lfsr_reg[30:0], ^(lfsr_reg & LFSR_TAPS)};
    int_data_next  = int_data_reg;
    int_valid_next = int_valid_reg;
    valid_next     = valid_reg;
    boot_ok_next   = boot_ok_reg;
    rsp_valid_next = 1'b0;
    status_next    = status_reg;
    rdata_next     = rdata_reg;
    lock_en        = 1'b0;
    ok             = 1'b0;
    bad_sig        = 1'b0;
    save           = 1'b0;
    res            = '0;
    if (link.req && !rsp_valid_reg) begin
      rsp_valid_next = 1'b1;
      if (!io_bad) begin
        unique case (link.op)
          CMD_READ: begin
            ok  = !NO_READ_MASK[s]; // [R1] [R24]
            res = slot_mem[s];
          end
          CMD_WRITE: begin
            if (s == SLOT_SECRET) begin
              ok = link.enc_write && io_ready && !locked; // [R16]
            end else begin
              ok = !NO_WRITE_MASK[s] && !locked // [R2] [R7] [R23]
                   && !(s == SLOT_VALIDATED && valid_reg) // [R8]
                   && !(cert && CERT_PERMANENT); // [R11]
            end
            if (ok && s == SLOT_SECRET) begin
              slot_next[s] = link.wdata ^ iokey; // [R16]
            end else if (ok && s == SLOT_AES) begin
              aes_next[aes_idx] = link.wdata;
            end else if (ok) begin
              slot_next[s] = link.wdata;
            end
          end
          CMD_GENKEY: begin
            if (m == MODE_PUBKEY) begin
              ok  = is_private(s) && (s != SLOT_PRIMARY || prim_ok); // [R3] [R14]
              res = mix(slot_mem[s], '0);
            end else if (m == MODE_REGEN) begin
              ok  = is_secondary(s) && !locked; // [R2] [R4] [R5]
              res = mix(lfsr_reg, '0);
              if (ok) begin
                slot_next[s] = lfsr_reg; // [R4]
              end
            end
            if (ok) begin
              int_valid_next = 1'b1; // [R6]
              int_data_next  = res;
            end
          end
          CMD_LOCK: begin
            ok      = LOCKABLE_MASK[s] && !locked && !(cert && CERT_PERMANENT); // [R5] [R11] [R23]
            lock_en = ok; // [R22]
          end
          CMD_SIGN: begin
            if (s == SLOT_ATTEST) begin
              ok  = int_valid_reg; // [R6]
              res = mix(slot_mem[s], int_data_reg);
              int_valid_next = 1'b0;
            end else begin
              ok  = use_ok; // [R2] [R14]
              res = mix(slot_mem[s], din);
            end
          end
          CMD_ECDH: begin
            ok   = use_ok; // [R2] [R14]
            res  = mix(slot_mem[s], din);
            save = m[MODE_SAVE_BIT];
          end
          CMD_VERIFY: begin
            ok = s == SLOT_VALIDATED && !slot_lock_state_bits[SLOT_PARENT]; // [R7]
            if (sub == SUB_USE) begin
              ok      = ok && valid_reg; // [R8]
              bad_sig = din != mix(slot_mem[s], '0);
            end else begin
              bad_sig = din != mix(slot_mem[SLOT_PARENT], slot_mem[s]);
              if (ok && !bad_sig) begin
                valid_next = sub == SUB_VALIDATE; // [R8]
              end
            end
          end
          CMD_DIGEST: begin
            ok  = is_sym(s); // [R15]
            res = mix(key, din);
            if (ok) begin
              int_valid_next = 1'b1; // [R6]
              int_data_next  = res;
            end
          end
          CMD_MAC: begin
            ok  = is_sym(s); // [R15]
            res = mix(key, din);
          end
          CMD_BOOT: begin
            ok = !slot_lock_state_bits[SLOT_BOOT_PUB]; // [R12]
            if (sub == SUB_BOOT_UPDATE) begin
              if (ok) begin
                slot_next[SLOT_BOOT_DIG] = din; // [R13]
              end
            end else begin
              bad_sig = din != mix(slot_mem[SLOT_BOOT_PUB], slot_mem[SLOT_BOOT_DIG]);
              if (ok) begin
                boot_ok_next = !bad_sig; // [R13] [R14]
              end
            end
          end
          CMD_RANDOM: begin
            ok  = 1'b1;
            res = lfsr_reg;
          end
          CMD_KDF: begin
            ok   = is_sym(s); // [R15]
            res  = mix(key, din);
            save = m[MODE_SAVE_BIT];
          end
          default: ok = 1'b0;
        endcase
      end
      if (ok && save) begin
        aes_next[aes_idx] = res; // [R17]
      end
      if (ok && prot && enc) begin
        res = res ^ iokey; // [R18]
      end
      status_next = !ok ? ST_DENIED : (bad_sig ? ST_BAD_SIG : ST_OK); // [R24]
      rdata_next  = (ok && !bad_sig) ? res : '0; // [R1] [R24]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_mem[i] <= KEY_SEED ^ 32'(i);
      end
      for (int j = 0; j < AES_ENTRIES; j++) begin
        aes_mem[j] <= '0;
      end
      lfsr_reg      <= KEY_SEED;
      int_data_reg  <= '0;
      int_valid_reg <= 1'b0;
      valid_reg     <= 1'b0;
      boot_ok_reg   <= 1'b0;
      rsp_valid_reg <= 1'b0;
      status_reg    <= ST_OK;
      rdata_reg     <= '0;
    end else begin
      slot_mem      <= slot_next;
      aes_mem       <= aes_next;
      lfsr_reg      <= lfsr_next;
      int_data_reg  <= int_data_next;
      int_valid_reg <= int_valid_next;
      valid_reg     <= valid_next;
      boot_ok_reg   <= boot_ok_next;
      rsp_valid_reg <= rsp_valid_next;
      status_reg    <= status_next;
      rdata_reg     <= rdata_next;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/key_slot_host.sv */
`timescale 1ns/1ps
`default_nettype none
module key_slot_host
  import key_slot_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  key_slot_if.host         link
);
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_RAND, H_WRITE, H_LOCK, H_CHECK} hstate_t;

  hstate_t     state_reg, state_next;
  cmd_t        c_op_reg, c_op_next, op_reg, op_next;
  logic [7:0]  c_mode_reg, c_mode_next, mode_reg, mode_next;
  logic [3:0]  c_slot_reg, c_slot_next, slot_reg, slot_next;
  logic [31:0] din_reg, din_next, dout_reg, dout_next;
  logic [31:0] iokey_reg, iokey_next, wdata_reg, wdata_next;
  logic [31:0] prdata_reg, prdata_next;
  status_t     status_reg, status_next;
  logic [15:0] locks_reg, locks_next;
  logic        paired_reg, paired_next, pair_ok_reg, pair_ok_next;
  logic        req_reg, req_next, encw_reg, encw_next;
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic        sel, take, mapped, deny, c_enc, rsp_ok;

  assign sel    = psel && penable;
  assign take   = sel && pready_reg;
  assign mapped = paddr == REG_CTRL || paddr == REG_CMD || paddr == REG_DIN
                  || paddr == REG_DOUT || paddr == REG_STAT;
  assign c_enc  = is_prot(c_op_reg) && c_mode_reg[MODE_ENC_BIT];
  assign rsp_ok = link.status == ST_OK;
  assign deny   = (c_op_reg == CMD_LOCK && c_slot_reg == SLOT_VALIDATED) // [R9]
                  || (c_op_reg == CMD_VERIFY && !locks_reg[SLOT_PARENT]) // [R7]
                  || (c_op_reg == CMD_BOOT && !locks_reg[SLOT_BOOT_PUB]) // [R12]
                  || (c_enc && !paired_reg) // [R20]
                  || (c_op_reg == CMD_WRITE && c_slot_reg == SLOT_SECRET && !paired_reg); // [R16]

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign link.req       = req_reg;
  assign link.op        = op_reg;
  assign link.mode      = mode_reg;
  assign link.slot      = slot_reg;
  assign link.wdata     = wdata_reg;
  assign link.enc_write = encw_reg;

  always_comb begin
    {c_op_next, c_mode_next, c_slot_next, din_next} = {c_op_reg, c_mode_reg, c_slot_reg, din_reg};
    {dout_next, iokey_next, status_next, locks_next} = {dout_reg, iokey_reg, status_reg, locks_reg};
    {paired_next, pair_ok_next, state_next} = {paired_reg, pair_ok_reg, state_reg};
    {req_next, op_next, mode_next, slot_next} = {req_reg, op_reg, mode_reg, slot_reg};
    {wdata_next, encw_next} = {wdata_reg, encw_reg};
    pready_next  = sel && !pready_reg;
    pslverr_next = sel && !pready_reg && !mapped;
    prdata_next  = prdata_reg;
    if (sel && !pready_reg) begin
      prdata_next = '0;
      if (paddr == REG_CMD) begin
        prdata_next[CMD_OP_LSB +: 4]   = c_op_reg;
        prdata_next[CMD_MODE_LSB +: 8] = c_mode_reg;
        prdata_next[CMD_SLOT_LSB +: 4] = c_slot_reg;
      end else if (paddr == REG_DIN) begin
        prdata_next = din_reg;
      end else if (paddr == REG_DOUT) begin
        prdata_next = dout_reg;
      end else if (paddr == REG_STAT) begin
        prdata_next[STAT_BUSY]          = state_reg != H_IDLE;
        prdata_next[STAT_ST_LSB +: 2]   = status_reg;
        prdata_next[STAT_PAIRED]        = paired_reg;
        prdata_next[STAT_PAIR_OK]       = pair_ok_reg;
        prdata_next[STAT_LOCKS_LSB +: 16] = locks_reg;
      end
    end
    if (req_reg && link.rsp_valid) begin
      req_next    = 1'b0;
      encw_next   = 1'b0;
      status_next = link.status;
      state_next  = H_IDLE;
      unique case (state_reg)
        H_IDLE: begin
          state_next = H_IDLE;
        end
        H_CMD: begin
          dout_next = c_enc ? link.rdata ^ iokey_reg : link.rdata;
          if (op_reg == CMD_LOCK && rsp_ok) begin
            locks_next[slot_reg] = 1'b1;
          end
        end
        H_RAND: begin
          if (rsp_ok) begin
            iokey_next = link.rdata; // [R19]
            {req_next, op_next, slot_next, wdata_next} = {1'b1, CMD_WRITE, SLOT_IOKEY, link.rdata};
            state_next = H_WRITE; // [R19]
          end
        end
        H_WRITE: begin
          if (rsp_ok) begin
            {req_next, op_next, slot_next} = {1'b1, CMD_LOCK, SLOT_IOKEY};
            state_next = H_LOCK; // [R19]
          end
        end
        H_LOCK: begin
          paired_next = rsp_ok; // [R19]
          if (rsp_ok) begin
            locks_next[SLOT_IOKEY] = 1'b1;
          end
        end
        H_CHECK: begin
          pair_ok_next = rsp_ok && link.rdata == mix(iokey_reg, din_reg); // [R21]
        end
      endcase
    end
    if (take && pwrite) begin
      if (paddr == REG_CMD) begin
        c_op_next   = cmd_t'(pwdata[CMD_OP_LSB +: 4]);
        c_mode_next = pwdata[CMD_MODE_LSB +: 8];
        c_slot_next = pwdata[CMD_SLOT_LSB +: 4];
      end else if (paddr == REG_DIN) begin
        din_next = pwdata;
      end else if (paddr == REG_CTRL && state_reg == H_IDLE) begin
        mode_next = '0;
        if (pwdata[CTRL_GO] && deny) begin
          status_next = ST_DENIED;
        end else if (pwdata[CTRL_GO]) begin
          {req_next, op_next, mode_next, slot_next} = {1'b1, c_op_reg, c_mode_reg, c_slot_reg};
          encw_next  = c_op_reg == CMD_WRITE && c_slot_reg == SLOT_SECRET; // [R16]
          wdata_next = (encw_next || c_enc) ? din_reg ^ iokey_reg : din_reg; // [R16] [R18]
          state_next = H_CMD;
        end else if (pwdata[CTRL_PAIR]) begin
          {req_next, op_next, slot_next} = {1'b1, CMD_RANDOM, SLOT_IOKEY};
          state_next = H_RAND; // [R19]
        end else if (pwdata[CTRL_CHECK]) begin
          {req_next, op_next, slot_next, wdata_next} = {1'b1, CMD_MAC, SLOT_IOKEY, din_reg};
          state_next = H_CHECK; // [R21]
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {c_op_reg, op_reg, status_reg, state_reg} <= {CMD_READ, CMD_READ, ST_OK, H_IDLE};
      {c_mode_reg, c_slot_reg, mode_reg, slot_reg} <= '0;
      {din_reg, dout_reg, iokey_reg, wdata_reg, prdata_reg} <= '0;
      {locks_reg, paired_reg, pair_ok_reg, req_reg, encw_reg} <= '0;
      {pready_reg, pslverr_reg} <= '0;
    end else begin
      {c_op_reg, op_reg, status_reg, state_reg} <= {c_op_next, op_next, status_next, state_next};
      {c_mode_reg, c_slot_reg, mode_reg, slot_reg} <= {c_mode_next, c_slot_next, mode_next, slot_next};
      {din_reg, dout_reg, iokey_reg} <= {din_next, dout_next, iokey_next};
      {wdata_reg, prdata_reg} <= {wdata_next, prdata_next};
      {locks_reg, paired_reg, pair_ok_reg} <= {locks_next, paired_next, pair_ok_next};
      {req_reg, encw_reg, pready_reg, pslverr_reg} <= {req_next, encw_next, pready_next, pslverr_next};
    end
  end
endmodule
`default_nettype wire

/* File: tb/key_slot_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module key_slot_asserts
  import key_slot_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        req,
  input wire cmd_t        op,
  input wire logic [7:0]  mode,
  input wire logic [3:0]  slot,
  input wire logic [31:0] wdata,
  input wire logic        enc_write,
  input wire logic        rsp_valid,
  input wire status_t     status,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic tk;
  assign tk = req && !rsp_valid;
  sequence denied_rsp;
    rsp_valid && status == ST_DENIED && rdata == 32'h0;
  endsequence
  a_rsp_latency: assert property (tk |=> rsp_valid)
    else $error("no answer after request");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_priv_no_read: assert property (tk && op == CMD_READ && slot <= 4'h4 |=> denied_rsp)
    else $error("private slot read allowed");
  a_secret_no_read: assert property (tk && op == CMD_READ && slot inside {[4'h5:4'h7]}
    |=> denied_rsp)
    else $error("secret slot read allowed");
  a_prim_fixed: assert property (tk && slot == 4'h0 && (op == CMD_WRITE
    || (op == CMD_GENKEY && mode == 8'h04)) |=> denied_rsp)
    else $error("primary key changed");
  a_pubkey_ok: assert property (tk && op == CMD_GENKEY && mode == 8'h00 && slot == 4'h0
    |=> rsp_valid && status == ST_OK)
    else $error("public key refused");
  a_digest_nowr: assert property (tk && op == CMD_WRITE && slot == 4'h7 |=> denied_rsp)
    else $error("digest slot written");
  a_deny_empty: assert property (rsp_valid && status != ST_OK |-> rdata == 32'h0)
    else $error("data on refused answer");
  a_valid_unlocked: assert property (!(req && op == CMD_LOCK && slot == 4'hE))
    else $error("validated slot lock sent");
endmodule
`default_nettype wire

/* File: tb/tb_key_slot_access_policy.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, v); end end
module tb_key_slot_access_policy
  import key_slot_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic        pready, pslverr, err, boot_ok, kval;
  logic [15:0] lock_bits;
  int          bad_count = 0, num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  key_slot_if key_slot_if_i (.clk_sys(clk_sys), .rst_n(rst_n));
  key_slot_device key_slot_device_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(key_slot_if_i.dev), .slot_lock_state_bits(lock_bits), .boot_ok(boot_ok),
    .key_validated(kval));
  key_slot_host key_slot_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(key_slot_if_i.host));
  key_slot_asserts key_slot_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .req(key_slot_if_i.req), .op(key_slot_if_i.op), .mode(key_slot_if_i.mode),
    .slot(key_slot_if_i.slot), .wdata(key_slot_if_i.wdata),
    .enc_write(key_slot_if_i.enc_write), .rsp_valid(key_slot_if_i.rsp_valid),
    .status(key_slot_if_i.status), .rdata(key_slot_if_i.rdata));
  function automatic logic [31:0] pk(input logic [31:0] a);
    return {a[15:0], a[31:16]} ^ MIX_CONST;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wt();
    do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
    st = rd;
    apb(1'b0, REG_DOUT, 32'h0);
  endtask
  task automatic t(input cmd_t o, input logic [7:0] m, input logic [3:0] s,
                   input logic [31:0] d, input status_t e);
    apb(1'b1, REG_CMD, {12'h000, s, m, 4'h0, o});
    apb(1'b1, REG_DIN, d);
    apb(1'b1, REG_CTRL, 32'h1);
    wt();
    `CHK("status", e, st[2:1])
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("locks", LOCK_RESET, lock_bits)
    for (int s = 0; s < 8; s++) begin
      t(CMD_READ, 8'h00, s[3:0], 32'h0, ST_DENIED);
      `CHK("read data", 32'h0, rd)
    end
    for (int s = 10; s < 13; s++) begin
      t(CMD_READ, 8'h00, s[3:0], 32'h0, ST_OK);
      `CHK("cert", KEY_SEED ^ s, rd)
    end
    $display("read test done");
    t(CMD_GENKEY, MODE_PUBKEY, SLOT_PRIMARY, 32'h0, ST_OK);
    `CHK("pubkey", pk(KEY_SEED), rd)
    t(CMD_SIGN, 8'h00, SLOT_ATTEST, 32'h1234, ST_OK);
    t(CMD_SIGN, 8'h00, SLOT_ATTEST, 32'h1234, ST_DENIED);
    t(CMD_GENKEY, MODE_REGEN, SLOT_PRIMARY, 32'h0, ST_DENIED);
    t(CMD_WRITE, 8'h00, SLOT_PRIMARY, 32'h7, ST_DENIED);
    t(CMD_GENKEY, MODE_REGEN, SLOT_SEC_LO, 32'h0, ST_OK);
    t(CMD_LOCK, 8'h00, SLOT_SEC_LO, 32'h0, ST_OK);
    `CHK("locks", 16'hFFFB, lock_bits)
    t(CMD_GENKEY, MODE_REGEN, SLOT_SEC_LO, 32'h0, ST_DENIED);
    t(CMD_LOCK, 8'h00, SLOT_SEC_LO, 32'h0, ST_DENIED);
    t(CMD_WRITE, 8'h00, SLOT_BOOT_DIG, 32'h9, ST_DENIED);
    t(CMD_WRITE, 8'h00, SLOT_SECRET, 32'h9, ST_DENIED);
    t(CMD_VERIFY, 8'h00, SLOT_PARENT, 32'h0, ST_DENIED);
    t(CMD_BOOT, 8'h00, SLOT_BOOT_PUB, 32'h0, ST_DENIED);
    t(CMD_ECDH, 8'h80, SLOT_PRIMARY, 32'h3, ST_DENIED);
    t(CMD_LOCK, 8'h00, SLOT_VALIDATED, 32'h0, ST_DENIED);
    $display("policy test done");
    apb(1'b1, REG_CTRL, 32'h2);
    wt();
    `CHK("paired", 1'b1, st[STAT_PAIRED])
    `CHK("locks", 16'hFFBB, lock_bits)
    apb(1'b1, REG_DIN, 32'h55);
    apb(1'b1, REG_CTRL, 32'h4);
    wt();
    `CHK("pair ok", 1'b1, st[STAT_PAIR_OK])
    t(CMD_ECDH, 8'h80, SLOT_PRIMARY, 32'h3, ST_OK);
    `CHK("ecdh", pk(KEY_SEED) ^ 32'h3, rd)
    t(CMD_WRITE, 8'h00, SLOT_SECRET, 32'h9, ST_OK);
    t(CMD_MAC, 8'h00, SLOT_SECRET, 32'h2, ST_OK);
    `CHK("mac", pk(32'h9) ^ 32'h2, rd)
    t(CMD_LOCK, 8'h00, SLOT_PARENT, 32'h0, ST_OK);
    t(CMD_VERIFY, 8'h00, SLOT_VALIDATED, pk(KEY_SEED ^ 13) ^ KEY_SEED ^ 14, ST_OK);
    `CHK("valid", 1'b1, kval)
    t(CMD_WRITE, 8'h00, SLOT_VALIDATED, 32'h1, ST_DENIED);
    t(CMD_LOCK, 8'h00, SLOT_BOOT_PUB, 32'h0, ST_OK);
    t(CMD_BOOT, 8'h01, SLOT_BOOT_PUB, 32'h5, ST_OK);
    t(CMD_BOOT, 8'h00, SLOT_BOOT_PUB, pk(KEY_SEED ^ 15) ^ 32'h5, ST_OK);
    `CHK("boot", 1'b1, boot_ok)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("pairing test done");
    give_verdict();
  end
endmodule
`default_nettype wire
